// ===== core/sirar_pkg.sv
// Register map, field layout, reset values and timing for the rate access regs
//
// How it works
// R1: Pending bit 0 of command state is high while a table command runs.
// R2: Write value bits 15:0 are stored into the selected table entry.
// R3: A read command returns the selected entry in read value bits 15:0.
// R4: Each port counter counts packets filtered at ingress on that port, except rate drops.
// R5: Packets dropped by ingress rate limiting are never counted here.
// R6: A counter read returns its value and clears it; reset value is zero.
// R7: Counters saturate at all ones and stay until cleared by a read.
// R8: Port 0 remap holds eight 3-bit fields; bits 3n+2:3n serve priority n.
// R9: Queue selection uses the remapped priority, not the received one.
// R10: Remap fields reset to identity, seven down to zero.
// R11: Reserved upper bits read as zero and ignore writes.
// R12: Command bit 7 read/write, bits 6:5 entry type, bits 4:0 rate index.
// R13: Table holds 24 committed-rate entries plus two burst entries, 16 bits.
// R14: Software waits for pending low, and loads write value before writing.
package sirar_pkg;

    // Register indices; byte address is four times the index
    localparam int          IDX_W            = 14;
    localparam logic [13:0] IDX_RATE_CMD     = 14'h184B;
    localparam logic [13:0] IDX_CMD_STATE    = 14'h184C;
    localparam logic [13:0] IDX_WRITE_VALUE  = 14'h184D;
    localparam logic [13:0] IDX_READ_VALUE   = 14'h184E;
    localparam logic [13:0] IDX_DROP_CNT0    = 14'h1850;
    localparam logic [13:0] IDX_DROP_CNT1    = 14'h1851;
    localparam logic [13:0] IDX_DROP_CNT2    = 14'h1852;
    localparam logic [13:0] IDX_PRIO_REMAP   = 14'h1855;

    // Command register fields
    localparam int          CMD_W            = 8;
    localparam int          CMD_RD_BIT       = 7;
    localparam int          CMD_TYPE_LSB     = 5;
    localparam int          CMD_ADDR_W       = 5;
    localparam logic [1:0]  TYPE_RESERVED    = 2'h0;
    localparam logic [1:0]  TYPE_RATE        = 2'h1;
    localparam logic [1:0]  TYPE_CBS         = 2'h2;
    localparam logic [1:0]  TYPE_EBS         = 2'h3;
    localparam int          PENDING_BIT      = 0;

    // Metering table
    localparam int          ENTRY_W          = 16;
    localparam int          RATE_ENTRIES     = 24;
    localparam logic [15:0] RATE_RST         = 16'h0014;
    localparam logic [15:0] BURST_RST        = 16'h0600;
    localparam logic [15:0] WRITE_VALUE_RST  = 16'h0000;

    // Counters and remap table
    localparam int          CNT_W            = 32;
    localparam int          PORTS            = 3;
    localparam int          PRIO_W           = 3;
    localparam int          REMAP_W          = 24;
    localparam logic [23:0] REMAP_RST        = 24'hFAC688;

    // Cycles a table command spends waiting before it executes
    localparam int          CMD_WAIT_CYCLES  = 3;

    typedef enum logic [1:0] {
        SIRAR_IDLE = 2'b00,
        SIRAR_WAIT = 2'b01,
        SIRAR_EXEC = 2'b11
    } sirar_state_t;

endpackage

// ===== core/sirar_regs.sv
// APB register bank: rate table access, filtered counters, port 0 remap
`timescale 1ns/1ps
`default_nettype none
module sirar_regs
    import sirar_pkg::*;
#(
    parameter int CMD_CYCLES = sirar_pkg::CMD_WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    // APB slave
    input  wire logic [15:0]              paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Ingress filter events, one bit per port
    input  wire logic [sirar_pkg::PORTS-1:0] port_filtered,
    input  wire logic [sirar_pkg::PORTS-1:0] port_rate_drop,
    // Port 0 priority regeneration
    input  wire logic                     rx_prio_valid,
    input  wire logic [2:0]               rx_prio,
    output logic                          queue_prio_valid,
    output logic      [2:0]               queue_prio
);
    import sirar_pkg::*;

    localparam int PEND_LAST = CMD_CYCLES;
    localparam logic [7:0] CNT_LAST = 8'(CMD_CYCLES - 1);

    function automatic logic hit(input logic [IDX_W-1:0] a,
                                 input logic [IDX_W-1:0] i);
        return a == i;
    endfunction

    function automatic logic [31:0] pad16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    sirar_state_t             state_q;
    logic [7:0]               wait_q;
    logic [CMD_W-1:0]         cmd_q;
    logic [ENTRY_W-1:0]       wr_value_q;
    logic [ENTRY_W-1:0]       rd_value_q;
    logic [ENTRY_W-1:0]       rate_q [RATE_ENTRIES];
    logic [ENTRY_W-1:0]       cbs_q;
    logic [ENTRY_W-1:0]       ebs_q;
    logic [REMAP_W-1:0]       remap_q;
    logic [CNT_W-1:0]         cnt_q [PORTS];
    logic [31:0]              prdata_q;
    logic                     cap_q;
    logic                     mapped_q;
    logic                     queue_valid_q;
    logic [2:0]               queue_prio_q;

    logic [IDX_W-1:0]         idx;
    logic                     wr_done;
    logic                     rd_done;
    logic                     pend;
    logic                     issue;
    logic                     exec;
    logic                     exec_rd;
    logic [1:0]               exec_type;
    logic [CMD_ADDR_W-1:0]    exec_addr;
    logic                     rate_ok;
    logic [31:0]              rd_mux;
    logic                     rd_map;
    logic [PORTS-1:0]         cnt_clr;
    logic [PORTS-1:0]         cnt_inc;

    assign idx       = paddr[15:2];
    // Read data is captured one cycle ahead, so no data path runs from the
    // registers to prdata combinationally; the cost is that stalled ce
    // stretches the access phase
    assign pready    = psel && penable && cap_q && ce;
    assign pslverr   = pready && !mapped_q;
    assign prdata    = prdata_q;
    assign wr_done   = pready && pwrite && mapped_q;
    assign rd_done   = pready && !pwrite && mapped_q;

    assign pend      = (state_q != SIRAR_IDLE); // R1
    assign issue     = wr_done && hit(idx, IDX_RATE_CMD) && !pend;
    assign exec      = (state_q == SIRAR_EXEC);
    assign exec_rd   = cmd_q[CMD_RD_BIT]; // R12
    assign exec_type = cmd_q[CMD_TYPE_LSB +: 2]; // R12
    assign exec_addr = cmd_q[CMD_ADDR_W-1:0]; // R12
    assign rate_ok   = (32'(exec_addr) < RATE_ENTRIES); // R13

    // Read decode, evaluated in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b1;
        case (idx)
            IDX_RATE_CMD:    rd_mux = {24'h000000, cmd_q};
            IDX_CMD_STATE:   rd_mux = {31'h0, pend}; // R1 R11
            IDX_WRITE_VALUE: rd_mux = pad16(wr_value_q); // R11
            IDX_READ_VALUE:  rd_mux = pad16(rd_value_q); // R3 R11
            IDX_DROP_CNT0:   rd_mux = cnt_q[0];
            IDX_DROP_CNT1:   rd_mux = cnt_q[1];
            IDX_DROP_CNT2:   rd_mux = cnt_q[2];
            IDX_PRIO_REMAP:  rd_mux = {8'h00, remap_q}; // R11
            default:         rd_map = 1'b0;
        endcase
    end

    // APB capture: one register cycle per transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_q    <= 1'b0;
            mapped_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (pready) begin
                cap_q <= 1'b0;
            end else if (psel && !cap_q) begin
                cap_q    <= 1'b1;
                mapped_q <= rd_map;
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_q      <= '0;
            wr_value_q <= WRITE_VALUE_RST;
            remap_q    <= REMAP_RST; // R10
        end else if (ce && wr_done) begin
            // A new command while one is pending is dropped
            if (issue) begin
                cmd_q <= pwdata[CMD_W-1:0]; // R12
            end
            if (hit(idx, IDX_WRITE_VALUE)) begin
                wr_value_q <= pwdata[ENTRY_W-1:0]; // R11
            end
            if (hit(idx, IDX_PRIO_REMAP)) begin
                remap_q <= pwdata[REMAP_W-1:0]; // R8 R11
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SIRAR_IDLE;
            wait_q  <= 8'h00;
        end else if (ce) begin
            case (state_q)
                SIRAR_IDLE: begin
                    wait_q <= 8'h00;
                    if (issue) begin
                        state_q <= SIRAR_WAIT; // R1
                    end
                end
                SIRAR_WAIT: begin
                    if (wait_q >= CNT_LAST) begin
                        state_q <= SIRAR_EXEC;
                    end else begin
                        wait_q <= wait_q + 8'h01;
                    end
                end
                SIRAR_EXEC: begin
                    state_q <= SIRAR_IDLE; // R1
                end
                default: begin
                    state_q <= SIRAR_IDLE;
                end
            endcase
        end
    end

    // Metering table writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < RATE_ENTRIES; i++) begin
                rate_q[i] <= RATE_RST;
            end
            cbs_q <= BURST_RST;
            ebs_q <= BURST_RST;
        end else if (ce && exec && !exec_rd) begin
            case (exec_type)
                TYPE_RATE: begin
                    if (rate_ok) begin
                        rate_q[exec_addr] <= wr_value_q; // R2 R13
                    end
                end
                TYPE_CBS: cbs_q <= wr_value_q; // R2
                TYPE_EBS: ebs_q <= wr_value_q; // R2
                default: begin
                end
            endcase
        end
    end

    // Metering table reads; reserved type or bad index returns zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_value_q <= '0;
        end else if (ce && exec && exec_rd) begin
            case (exec_type)
                TYPE_RATE: rd_value_q <= rate_ok ? rate_q[exec_addr] : '0; // R3
                TYPE_CBS: rd_value_q <= cbs_q; // R3
                TYPE_EBS: rd_value_q <= ebs_q; // R3
                default:  rd_value_q <= '0;
            endcase
        end
    end

    // Filtered-packet counters
    for (genvar p = 0; p < PORTS; p++) begin : g_cnt
        // Rate-limit drops are counted by the meter, not here
        assign cnt_inc[p] = port_filtered[p] && !port_rate_drop[p]; // R4 R5
        assign cnt_clr[p] = rd_done && hit(idx, IDX_DROP_CNT0 + 14'(p)); // R6
        sirar_sat_cnt #(
            .W       (CNT_W)
        ) u_cnt (
            .clk     (clk),
            .rst     (rst),
            .ce      (ce),
            .inc     (cnt_inc[p]),
            .clr     (cnt_clr[p]),
            .snap    (prdata_q),
            .count_q (cnt_q[p])
        );
    end

    // Priority regeneration for output queue selection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            queue_valid_q <= 1'b0;
            queue_prio_q  <= 3'h0;
        end else if (ce) begin
            queue_valid_q <= rx_prio_valid;
            if (rx_prio_valid) begin
                queue_prio_q <= remap_q[5'(rx_prio) * 5'd3 +: PRIO_W]; // R8 R9
            end
        end
    end

    assign queue_prio_valid = queue_valid_q;
    assign queue_prio       = queue_prio_q;

    // Checks
    sequence s_pend_run;
        pend [*1] ##(PEND_LAST) (pend ##1 !pend);
    endsequence

    a_pend_window: assert property (@(posedge clk) disable iff (rst || !ce)
        issue |=> s_pend_run) // R1
        else $error("pending flag window wrong");

    a_busy_cmd_held: assert property (@(posedge clk) disable iff (rst || !ce)
        pend && !exec |=> cmd_q == $past(cmd_q)) // R14
        else $error("command changed while pending");

    a_wr_cbs_store: assert property (@(posedge clk) disable iff (rst || !ce)
        exec && !exec_rd && exec_type == TYPE_CBS
        |=> cbs_q == $past(wr_value_q)) // R2
        else $error("burst entry not written");

    a_wr_rate_store: assert property (@(posedge clk) disable iff (rst || !ce)
        exec && !exec_rd && exec_type == TYPE_RATE && rate_ok
        |=> rate_q[$past(exec_addr)] == $past(wr_value_q)) // R2 R13
        else $error("rate entry not written");

    a_rd_ebs_return: assert property (@(posedge clk) disable iff (rst || !ce)
        exec && exec_rd && exec_type == TYPE_EBS
        |=> rd_value_q == $past(ebs_q) && !pend) // R3
        else $error("read value wrong");

    a_cnt_count_up: assert property (@(posedge clk) disable iff (rst || !ce)
        cnt_inc[0] && !cnt_clr[0] && cnt_q[0] != 32'hFFFF_FFFF
        |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1) // R4
        else $error("counter missed a filtered packet");

    a_cnt_rate_skip: assert property (@(posedge clk) disable iff (rst || !ce)
        port_rate_drop[1] && !cnt_clr[1] |=> cnt_q[1] == $past(cnt_q[1])) // R5
        else $error("rate drop was counted");

    a_cnt_read_clear: assert property (@(posedge clk) disable iff (rst || !ce)
        cnt_clr[2] && !cnt_inc[2] && prdata_q == cnt_q[2]
        |=> cnt_q[2] == 32'h0) // R6
        else $error("counter not cleared by read");

    a_remap_lookup: assert property (@(posedge clk) disable iff (rst || !ce)
        rx_prio_valid && rx_prio == 3'h7
        |=> queue_valid_q && queue_prio == $past(remap_q[23:21])) // R9
        else $error("queue priority not regenerated");

    a_remap_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> remap_q == REMAP_RST) // R10
        else $error("remap not identity after reset");

    a_resv_read_zero: assert property (@(posedge clk) disable iff (rst || !ce)
        pready && !pwrite && hit(idx, IDX_PRIO_REMAP)
        |-> prdata[31:24] == 8'h00) // R11
        else $error("reserved bits not zero");

    a_unmapped_err: assert property (@(posedge clk) disable iff (rst || !ce)
        psel && !penable && !rd_map && !cap_q ##1 pready |-> pslverr)
        else $error("unmapped access without error");

endmodule
`default_nettype wire

// ===== core/sirar_sat_cnt.sv
// Saturating clear-on-read packet counter
`timescale 1ns/1ps
`default_nettype none
module sirar_sat_cnt #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Events
    input  wire logic         inc,
    input  wire logic         clr,
    input  wire logic [W-1:0] snap,
    // Count
    output logic      [W-1:0] count_q
);
    logic [W-1:0] base;
    logic [W-1:0] count_d;

    // Clearing subtracts the value that was read, so events that arrive
    // between the read capture and the clear are kept
    always_comb begin
        base    = clr ? count_q - snap : count_q; // R6
        count_d = base;
        if (inc && (base != {W{1'b1}})) begin // R7
            count_d = base + {{(W-1){1'b0}}, 1'b1}; // R4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0; // R6
        end else if (ce) begin
            count_q <= count_d;
        end
    end

    a_cnt_sat_hold: assert property (@(posedge clk) disable iff (rst || !ce)
        (count_q == {W{1'b1}}) && !clr |=> count_q == {W{1'b1}}) // R7
        else $error("saturated counter moved");

endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the rate access register bank over APB
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sirar_pkg::*;

    logic        clk;
    logic        rst;
    logic        ce;
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  port_filtered;
    logic [2:0]  port_rate_drop;
    logic        rx_prio_valid;
    logic [2:0]  rx_prio;
    logic        queue_prio_valid;
    logic [2:0]  queue_prio;
    int          failures;
    int          checks_done;
    int          cycles;
    logic [31:0] d;
    logic        e;

    sirar_regs #(.CMD_CYCLES(3)) dut (
        .clk              (clk),
        .rst              (rst),
        .ce               (ce),
        .paddr            (paddr),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .port_filtered    (port_filtered),
        .port_rate_drop   (port_rate_drop),
        .rx_prio_valid    (rx_prio_valid),
        .rx_prio          (rx_prio),
        .queue_prio_valid (queue_prio_valid),
        .queue_prio       (queue_prio)
    );

    always #2.5 clk = ~clk;

    task automatic results();
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // A hang anywhere ends the run through the same report
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            $display("ERROR %0t: run did not finish", $time);
            results();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high; no latency assumed
    task automatic apb_xfer(input logic w, input logic [13:0] idx,
                            input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int   n;
        logic ok;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Sample mid-cycle so the completing edge is not raced
        @(negedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n = n + 1;
        end
        rd = prdata;
        err = pslverr;
        ok = pready;
        @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        chk_flag(ok, 1'b1);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, idx, wd, rd, err);
        chk_flag(err, 1'b0);
    endtask

    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b0, idx, 32'h0, rd, err);
        chk_word(rd, exp);
        chk_flag(err, 1'b0);
    endtask

    // Issue a command and poll pending under a bounded count
    task automatic tbl_cmd(input logic [7:0] cmd);
        logic [31:0] rd;
        logic        err;
        int          n;
        wr(IDX_RATE_CMD, {24'h0, cmd});
        apb_xfer(1'b0, IDX_CMD_STATE, 32'h0, rd, err);
        chk_word(rd, 32'h00000001);
        n = 0;
        while (rd[PENDING_BIT] !== 1'b0 && n < 20) begin
            apb_xfer(1'b0, IDX_CMD_STATE, 32'h0, rd, err);
            n = n + 1;
        end
        chk_word(rd, 32'h00000000);
    endtask

    task automatic tbl_wr(input logic [1:0] ty, input logic [4:0] idx,
                          input logic [15:0] v);
        wr(IDX_WRITE_VALUE, {16'h0, v});
        tbl_cmd({1'b0, ty, idx});
    endtask

    task automatic tbl_rd(input logic [1:0] ty, input logic [4:0] idx,
                          input logic [15:0] v);
        tbl_cmd({1'b1, ty, idx});
        rd_chk(IDX_READ_VALUE, {16'h0, v});
    endtask

    task automatic pulses(input logic [2:0] f, input logic [2:0] dr,
                          input int n);
        repeat (n) begin
            @(posedge clk);
            port_filtered  <= f;
            port_rate_drop <= dr;
        end
        @(posedge clk);
        port_filtered  <= 3'h0;
        port_rate_drop <= 3'h0;
    endtask

    task automatic prio_chk(input logic [23:0] map);
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            rx_prio_valid <= 1'b1;
            rx_prio       <= 3'(n);
            @(posedge clk);
            rx_prio_valid <= 1'b0;
            @(negedge clk);
            chk_flag(queue_prio_valid, 1'b1);
            chk_word({29'h0, queue_prio}, {29'h0, map[3*n +: 3]});
        end
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        paddr = 16'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        port_filtered = 3'h0;
        port_rate_drop = 3'h0;
        rx_prio_valid = 1'b0;
        rx_prio = 3'h0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk(IDX_CMD_STATE, 32'h00000000);
        rd_chk(IDX_WRITE_VALUE, 32'h00000000);
        rd_chk(IDX_READ_VALUE, 32'h00000000);
        rd_chk(IDX_DROP_CNT0, 32'h00000000);
        rd_chk(IDX_DROP_CNT1, 32'h00000000);
        rd_chk(IDX_DROP_CNT2, 32'h00000000);
        rd_chk(IDX_PRIO_REMAP, 32'h00FAC688);
        // Hole in the map between the counters and the remap register
        apb_xfer(1'b0, 14'h1853, 32'h0, d, e);
        chk_flag(e, 1'b1);
        wr(IDX_WRITE_VALUE, 32'hFFFFABCD);
        rd_chk(IDX_WRITE_VALUE, 32'h0000ABCD);
        wr(IDX_CMD_STATE, 32'hFFFFFFFF);
        rd_chk(IDX_CMD_STATE, 32'h00000000);
        wr(IDX_READ_VALUE, 32'hFFFFFFFF);
        rd_chk(IDX_READ_VALUE, 32'h00000000);
        tbl_rd(TYPE_RATE, 5'h00, 16'h0014);
        tbl_rd(TYPE_RATE, 5'h17, 16'h0014);
        tbl_rd(TYPE_CBS, 5'h00, 16'h0600);
        tbl_rd(TYPE_EBS, 5'h00, 16'h0600);
        tbl_wr(TYPE_RATE, 5'h17, 16'hBEEF);
        tbl_wr(TYPE_CBS, 5'h00, 16'h1234);
        tbl_wr(TYPE_EBS, 5'h00, 16'h5678);
        tbl_wr(TYPE_RATE, 5'h18, 16'hDEAD);
        tbl_wr(TYPE_RESERVED, 5'h03, 16'hDEAD);
        tbl_rd(TYPE_RATE, 5'h17, 16'hBEEF);
        tbl_rd(TYPE_RATE, 5'h16, 16'h0014);
        tbl_rd(TYPE_CBS, 5'h00, 16'h1234);
        tbl_rd(TYPE_EBS, 5'h00, 16'h5678);
        tbl_rd(TYPE_RATE, 5'h08, 16'h0014);
        tbl_rd(TYPE_RATE, 5'h03, 16'h0014);
        tbl_rd(TYPE_RATE, 5'h18, 16'h0000);
        tbl_rd(TYPE_RESERVED, 5'h03, 16'h0000);
        // Expected counts: port0 5, port1 6, port2 7
        pulses(3'b111, 3'b000, 3);
        pulses(3'b011, 3'b100, 2);
        pulses(3'b110, 3'b010, 4);
        pulses(3'b010, 3'b000, 1);
        rd_chk(IDX_DROP_CNT0, 32'h00000005);
        rd_chk(IDX_DROP_CNT1, 32'h00000006);
        rd_chk(IDX_DROP_CNT2, 32'h00000007);
        rd_chk(IDX_DROP_CNT0, 32'h00000000);
        rd_chk(IDX_DROP_CNT1, 32'h00000000);
        rd_chk(IDX_DROP_CNT2, 32'h00000000);
        // Clock enable low freezes the counters
        ce <= 1'b0;
        pulses(3'b111, 3'b000, 2);
        ce <= 1'b1;
        rd_chk(IDX_DROP_CNT0, 32'h00000000);
        rd_chk(IDX_DROP_CNT2, 32'h00000000);
        prio_chk(24'hFAC688);
        wr(IDX_PRIO_REMAP, 32'hFF123456);
        rd_chk(IDX_PRIO_REMAP, 32'h00123456);
        prio_chk(24'h123456);
        results();
    end

endmodule
`default_nettype wire
